// file: inc/adc_cfg_pkg.sv
package adc_cfg_pkg;
	// register map
	localparam logic [7:0] ADDR_CH3_PHASE = 8'h5D;
	localparam logic [7:0] ADDR_CH4_CLONE = 8'h5E;
	localparam logic [7:0] ADDR_CH4_VOL = 8'h5F;
	localparam logic [7:0] ADDR_CH4_TRIM = 8'h60;
	localparam logic [7:0] ADDR_CH4_PHASE = 8'h61;
	localparam logic [7:0] RST_PHASE = 8'h00;
	localparam logic [7:0] RST_CLONE = 8'h00;
	localparam logic [7:0] RST_VOL = 8'hA1;
	localparam logic [7:0] RST_TRIM = 8'h80;
	// field layout
	localparam int PHASE_LSB = 2;
	localparam int PHASE_W = 6;
	localparam int CLONE_BIT = 7;
	localparam int TRIM_LSB = 4;
	localparam int TRIM_W = 4;
	localparam int PHASE_MAX = 63;
	localparam logic [7:0] VOL_MUTE = 8'h00;
	localparam logic [7:0] VOL_UNITY = 8'hA1;
	localparam logic [3:0] TRIM_UNITY = 4'h8;
	// gain arithmetic: twelve half-dB steps per octave, Q2.14 tables
	localparam int Q_FRAC = 14;
	localparam logic [8:0] VOL_BIAS = 9'h007;
	localparam logic [8:0] OCT_STEPS = 9'h00C;
	localparam logic [4:0] SHIFT_BASE = 5'h1C;

	function automatic logic [15:0] vol_frac(input logic [3:0] k);
		case (k)
			4'h0: return 16'h4000;
			4'h1: return 16'h43CB;
			4'h2: return 16'h47CF;
			4'h3: return 16'h4C10;
			4'h4: return 16'h5092;
			4'h5: return 16'h5558;
			4'h6: return 16'h5A67;
			4'h7: return 16'h5FC2;
			4'h8: return 16'h656F;
			4'h9: return 16'h6B72;
			4'hA: return 16'h71D0;
			default: return 16'h788E;
		endcase
	endfunction

	function automatic logic [15:0] trim_lin(input logic [3:0] c);
		case (c)
			4'h0: return 16'h3A5F;
			4'h1: return 16'h3B0B;
			4'h2: return 16'h3BBA;
			4'h3: return 16'h3C6B;
			4'h4: return 16'h3D1F;
			4'h5: return 16'h3DD4;
			4'h6: return 16'h3E8B;
			4'h7: return 16'h3F44;
			4'h8: return 16'h4000;
			4'h9: return 16'h40BE;
			4'hA: return 16'h417E;
			4'hB: return 16'h4240;
			4'hC: return 16'h4304;
			4'hD: return 16'h43CB;
			4'hE: return 16'h4494;
			default: return 16'h455F;
		endcase
	endfunction
endpackage

// file: src/phase_delay_line.sv
`timescale 1ns/100ps
module phase_delay_line #(
	parameter int W = 16,
	parameter int DEPTH = 63
) (
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// modulator stream
	input wire logic [W-1:0] din,
	input wire logic [5:0] sel,
	output logic [W-1:0] dout
);
	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] line;
		logic [W-1:0] out;
	} state_s;

	state_s st_q;
	state_s st_d;

	// line[i] holds the input from i+1 cycles ago; out adds one fixed cycle
	always_comb begin
		st_d = st_q;
		st_d.line[0] = din;
		for (int i = 1; i < DEPTH; i++) begin
			st_d.line[i] = st_q.line[i-1];
		end
		if (sel == 6'h00) begin
			st_d.out = din;
		end else begin
			st_d.out = st_q.line[sel - 6'h01];
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign dout = st_q.out;
endmodule

// file: src/audio_gain_trim.sv
`timescale 1ns/100ps
module audio_gain_trim #(
	parameter int W = 24
) (
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// settings
	input wire logic [7:0] volCode,
	input wire logic [3:0] trimCode,
	// samples
	input wire logic [W-1:0] din,
	input wire logic dinValid,
	output logic [W-1:0] dout,
	output logic doutValid
);
	typedef struct packed {
		logic [W+1:0] s1;
		logic v1;
		logic [W-1:0] out;
		logic vo;
	} state_s;

	state_s st_q;
	state_s st_d;

	always_comb begin
		logic signed [W+16:0] p1;
		logic signed [W+18:0] p2;
		logic signed [W+18:0] r;
		logic signed [W+18:0] hi;
		logic [8:0] e;
		logic [4:0] n;
		logic [3:0] k;
		p1 = '0;
		p2 = '0;
		r = '0;
		hi = (W+19)'({1'b0, {(W-1){1'b1}}});
		e = {1'b0, volCode} + adc_cfg_pkg::VOL_BIAS;
		n = 5'(e / adc_cfg_pkg::OCT_STEPS);
		k = 4'(e % adc_cfg_pkg::OCT_STEPS);
		st_d = st_q;
		// stage 1: fine trim in 0.1 dB steps
		p1 = $signed(din) * $signed({1'b0, adc_cfg_pkg::trim_lin(trimCode)});
		st_d.s1 = p1[adc_cfg_pkg::Q_FRAC +: W+2];
		st_d.v1 = dinValid;
		// stage 2: half-dB step within an octave, then octave shift
		p2 = $signed(st_q.s1) * $signed({1'b0, adc_cfg_pkg::vol_frac(k)});
		r = p2 >>> (adc_cfg_pkg::SHIFT_BASE - n);
		st_d.vo = st_q.v1;
		if (st_q.v1) begin
			if (volCode == adc_cfg_pkg::VOL_MUTE) begin
				st_d.out = '0;
			end else if (r > hi) begin
				st_d.out = hi[W-1:0];
			end else if (r < -hi - 1) begin
				st_d.out = {1'b1, {(W-1){1'b0}}};
			end else begin
				st_d.out = r[W-1:0];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign dout = st_q.out;
	assign doutValid = st_q.vo;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	a_gain_latency:
		assert property (dinValid |-> ##2 doutValid)
		else $error("gain output not two cycles after input");
	a_mute_out:
		assert property (dinValid ##1 volCode == adc_cfg_pkg::VOL_MUTE
			|=> doutValid && dout == '0)
		else $error("muted channel produced nonzero sample");
	a_unity_gain:
		assert property ((dinValid && trimCode == adc_cfg_pkg::TRIM_UNITY)
			##1 volCode == adc_cfg_pkg::VOL_UNITY
			|=> dout == $past(din, 2))
		else $error("unity settings changed the sample");
	c_gain_out: cover property (doutValid && volCode == 8'hFF);
endmodule

// file: src/adc_ch3_ch4_digital_config.sv
`timescale 1ns/100ps
module adc_ch3_ch4_digital_config #(
	parameter int MOD_W = 16,
	parameter int AUD_W = 24
) (
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// register port
	input wire logic regWrEn,
	input wire logic regRdEn,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	output logic [7:0] regRdData,
	// modulator streams into the filters
	input wire logic [MOD_W-1:0] ch2ModIn,
	input wire logic [MOD_W-1:0] ch3ModIn,
	input wire logic [MOD_W-1:0] ch4ModIn,
	output logic [MOD_W-1:0] ch3ModOut,
	output logic [MOD_W-1:0] ch4ModOut,
	// channel 4 decimated audio
	input wire logic [AUD_W-1:0] ch4AudIn,
	input wire logic ch4AudInValid,
	output logic [AUD_W-1:0] ch4AudOut,
	output logic ch4AudOutValid
);
	typedef struct packed {
		logic [5:0] ch3Phase;
		logic [5:0] ch4Phase;
		logic ch4Clone;
		logic [7:0] ch4Vol;
		logic [3:0] ch4Trim;
		logic [7:0] rdData;
		logic [6:0] age;
	} state_s;

	localparam state_s RST_STATE = '{
		ch3Phase: adc_cfg_pkg::RST_PHASE[adc_cfg_pkg::PHASE_LSB +:
			adc_cfg_pkg::PHASE_W],
		ch4Phase: adc_cfg_pkg::RST_PHASE[adc_cfg_pkg::PHASE_LSB +:
			adc_cfg_pkg::PHASE_W],
		ch4Clone: adc_cfg_pkg::RST_CLONE[adc_cfg_pkg::CLONE_BIT],
		ch4Vol: adc_cfg_pkg::RST_VOL,
		ch4Trim: adc_cfg_pkg::RST_TRIM[adc_cfg_pkg::TRIM_LSB +:
			adc_cfg_pkg::TRIM_W],
		rdData: 8'h00,
		age: 7'h00
	};

	state_s st_q;
	state_s st_d;

	logic [MOD_W-1:0] ch4Src;

	// read image of a register; bits outside the fields read zero
	function automatic logic [7:0] read_reg(
		input logic [7:0] a,
		input state_s s
	);
		logic [7:0] r;
		r = 8'h00;
		case (a)
			adc_cfg_pkg::ADDR_CH3_PHASE: begin
				r = 8'(s.ch3Phase) << adc_cfg_pkg::PHASE_LSB;
			end
			adc_cfg_pkg::ADDR_CH4_CLONE: begin
				r = 8'(s.ch4Clone) << adc_cfg_pkg::CLONE_BIT;
			end
			adc_cfg_pkg::ADDR_CH4_VOL: begin
				r = s.ch4Vol;
			end
			adc_cfg_pkg::ADDR_CH4_TRIM: begin
				r = 8'(s.ch4Trim) << adc_cfg_pkg::TRIM_LSB;
			end
			adc_cfg_pkg::ADDR_CH4_PHASE: begin
				r = 8'(s.ch4Phase) << adc_cfg_pkg::PHASE_LSB;
			end
			default: begin
				r = 8'h00;
			end
		endcase
		return r;
	endfunction

	always_comb begin
		st_d = st_q;
		if (st_q.age != 7'h7F) begin
			st_d.age = st_q.age + 7'h01;
		end
		// only field bits are stored, so reserved bits stay zero
		if (regWrEn) begin
			case (regAddr)
				adc_cfg_pkg::ADDR_CH3_PHASE: begin
					st_d.ch3Phase = regWrData[adc_cfg_pkg::PHASE_LSB +:
						adc_cfg_pkg::PHASE_W];
				end
				adc_cfg_pkg::ADDR_CH4_CLONE: begin
					st_d.ch4Clone =
						regWrData[adc_cfg_pkg::CLONE_BIT];
				end
				adc_cfg_pkg::ADDR_CH4_VOL: begin
					st_d.ch4Vol = regWrData;
				end
				adc_cfg_pkg::ADDR_CH4_TRIM: begin
					st_d.ch4Trim = regWrData[adc_cfg_pkg::TRIM_LSB +:
						adc_cfg_pkg::TRIM_W];
				end
				adc_cfg_pkg::ADDR_CH4_PHASE: begin
					st_d.ch4Phase = regWrData[adc_cfg_pkg::PHASE_LSB +:
						adc_cfg_pkg::PHASE_W];
				end
				default: begin
					st_d.ch4Vol = st_q.ch4Vol;
				end
			endcase
		end
		if (regRdEn) begin
			st_d.rdData = read_reg(regAddr, st_q);
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			st_q <= RST_STATE;
		end else begin
			st_q <= st_d;
		end
	end

	// clone source selection ahead of the phase delay
	assign ch4Src = st_q.ch4Clone ? ch2ModIn : ch4ModIn;

	phase_delay_line #(
		.W(MOD_W),
		.DEPTH(adc_cfg_pkg::PHASE_MAX)
	) ch3Delay (
		.clk(clk),
		.resetn(resetn),
		.din(ch3ModIn),
		.sel(st_q.ch3Phase),
		.dout(ch3ModOut)
	);

	phase_delay_line #(
		.W(MOD_W),
		.DEPTH(adc_cfg_pkg::PHASE_MAX)
	) ch4Delay (
		.clk(clk),
		.resetn(resetn),
		.din(ch4Src),
		.sel(st_q.ch4Phase),
		.dout(ch4ModOut)
	);

	audio_gain_trim #(
		.W(AUD_W)
	) ch4Gain (
		.clk(clk),
		.resetn(resetn),
		.volCode(st_q.ch4Vol),
		.trimCode(st_q.ch4Trim),
		.din(ch4AudIn),
		.dinValid(ch4AudInValid),
		.dout(ch4AudOut),
		.doutValid(ch4AudOutValid)
	);

	assign regRdData = st_q.rdData;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	a_reset_values:
		assert property ($rose(resetn) |->
			st_q.ch4Vol == adc_cfg_pkg::RST_VOL
			&& st_q.ch4Trim == adc_cfg_pkg::TRIM_UNITY
			&& st_q.ch3Phase == '0 && st_q.ch4Phase == '0
			&& !st_q.ch4Clone)
		else $error("register not at reset value after reset");

	a_rsvd_read:
		assert property (regRdEn
			&& regAddr == adc_cfg_pkg::ADDR_CH4_CLONE
			|=> regRdData[adc_cfg_pkg::CLONE_BIT-1:0] == '0)
		else $error("reserved clone bits read nonzero");

	a_trim_read:
		assert property (regRdEn
			&& regAddr == adc_cfg_pkg::ADDR_CH4_TRIM
			|=> regRdData[adc_cfg_pkg::TRIM_LSB-1:0] == '0)
		else $error("reserved trim bits read nonzero");

	a_vol_write:
		assert property (regWrEn
			&& regAddr == adc_cfg_pkg::ADDR_CH4_VOL
			##1 regRdEn && regAddr == adc_cfg_pkg::ADDR_CH4_VOL
			|=> regRdData == $past(regWrData, 2))
		else $error("volume readback differs from write");

	a_clone_on:
		assert property (st_q.ch4Clone && st_q.ch4Phase == '0
			|=> ch4ModOut == $past(ch2ModIn))
		else $error("clone set but channel 4 not fed from channel 2");

	a_clone_off:
		assert property (!st_q.ch4Clone && st_q.ch4Phase == '0
			|=> ch4ModOut == $past(ch4ModIn))
		else $error("clone clear but channel 4 not own input");

	a_ph4_max:
		assert property (st_q.age == 7'h7F
			&& st_q.ch4Phase == 6'h3F
			|=> ch4ModOut == $past(ch4Src, 64))
		else $error("channel 4 max phase delay not 63 cycles");

	a_ph3_delay:
		assert property (st_q.age == 7'h7F
			&& st_q.ch3Phase == 6'h02
			|=> ch3ModOut == $past(ch3ModIn, 3))
		else $error("channel 3 phase delay of two cycles wrong");

	a_ph3_max:
		assert property (st_q.age == 7'h7F
			&& st_q.ch3Phase == 6'h3F
			|=> ch3ModOut == $past(ch3ModIn, 64))
		else $error("channel 3 max phase delay not 63 cycles");

	a_ph3_none:
		assert property (st_q.age == 7'h7F
			&& st_q.ch3Phase == 6'h00
			|=> ch3ModOut == $past(ch3ModIn))
		else $error("channel 3 zero phase setting added delay");

	a_ph4_one:
		assert property (st_q.age == 7'h7F
			&& st_q.ch4Phase == 6'h01
			|=> ch4ModOut == $past(ch4Src, 2))
		else $error("channel 4 one-cycle phase delay wrong");

	a_ph3_write:
		assert property (regWrEn
			&& regAddr == adc_cfg_pkg::ADDR_CH3_PHASE
			|=> st_q.ch3Phase == 6'($past(regWrData)
				>> adc_cfg_pkg::PHASE_LSB))
		else $error("channel 3 phase write not applied");

	a_ph4_write:
		assert property (regWrEn
			&& regAddr == adc_cfg_pkg::ADDR_CH4_PHASE
			|=> st_q.ch4Phase == 6'($past(regWrData)
				>> adc_cfg_pkg::PHASE_LSB))
		else $error("channel 4 phase write not applied");

	a_trim_write:
		assert property (regWrEn
			&& regAddr == adc_cfg_pkg::ADDR_CH4_TRIM
			|=> st_q.ch4Trim == 4'($past(regWrData)
				>> adc_cfg_pkg::TRIM_LSB))
		else $error("channel 4 trim write not applied");

	a_clone_write:
		assert property (regWrEn
			&& regAddr == adc_cfg_pkg::ADDR_CH4_CLONE
			|=> st_q.ch4Clone == 1'($past(regWrData)
				>> adc_cfg_pkg::CLONE_BIT))
		else $error("clone write not applied");

	a_ch3_apart:
		assert property (regWrEn
			&& regAddr != adc_cfg_pkg::ADDR_CH3_PHASE
			|=> $stable(st_q.ch3Phase))
		else $error("channel 3 phase changed by another write");

	a_vol_apart:
		assert property (regWrEn
			&& regAddr != adc_cfg_pkg::ADDR_CH4_VOL
			|=> $stable(st_q.ch4Vol))
		else $error("channel 4 volume changed by another write");

	a_ph_rsvd_read:
		assert property (regRdEn
			&& (regAddr == adc_cfg_pkg::ADDR_CH3_PHASE
			|| regAddr == adc_cfg_pkg::ADDR_CH4_PHASE)
			|=> regRdData[adc_cfg_pkg::PHASE_LSB-1:0] == '0)
		else $error("reserved phase bits read nonzero");

	a_unmapped_read:
		assert property (regRdEn
			&& (regAddr < adc_cfg_pkg::ADDR_CH3_PHASE
			|| regAddr > adc_cfg_pkg::ADDR_CH4_PHASE)
			|=> regRdData == 8'h00)
		else $error("unmapped address read nonzero");

	c_clone_write: cover property (regWrEn
		&& regAddr == adc_cfg_pkg::ADDR_CH4_CLONE
		&& regWrData[adc_cfg_pkg::CLONE_BIT]);
	c_mute_write: cover property (regWrEn
		&& regAddr == adc_cfg_pkg::ADDR_CH4_VOL
		&& regWrData == adc_cfg_pkg::VOL_MUTE);
	c_max_phase: cover property (st_q.ch4Phase == 6'h3F);
	c_unmapped_read: cover property (regRdEn
		&& regAddr > adc_cfg_pkg::ADDR_CH4_PHASE);
endmodule

// file: tb/adc_ch3_ch4_digital_config_test.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) begin \
	comparisons++; \
	if ((g) !== (e)) begin \
		mismatches++; \
		$display("MISMATCH %s expected %0h seen %0h", nm, e, g); \
	end \
end
module adc_ch3_ch4_digital_config_test;
	logic clk;
	logic resetn;
	logic regWrEn;
	logic regRdEn;
	logic [7:0] regAddr;
	logic [7:0] regWrData;
	logic [7:0] regRdData;
	logic [15:0] ch2ModIn;
	logic [15:0] ch3ModIn;
	logic [15:0] ch4ModIn;
	logic [15:0] ch3ModOut;
	logic [15:0] ch4ModOut;
	logic [23:0] ch4AudIn;
	logic ch4AudInValid;
	logic [23:0] ch4AudOut;
	logic ch4AudOutValid;
	int mismatches;
	int comparisons;

	adc_ch3_ch4_digital_config #(.MOD_W(16), .AUD_W(24))
	adc_ch3_ch4_digital_config_i (
		.clk(clk), .resetn(resetn),
		.regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr),
		.regWrData(regWrData), .regRdData(regRdData),
		.ch2ModIn(ch2ModIn), .ch3ModIn(ch3ModIn), .ch4ModIn(ch4ModIn),
		.ch3ModOut(ch3ModOut), .ch4ModOut(ch4ModOut),
		.ch4AudIn(ch4AudIn), .ch4AudInValid(ch4AudInValid),
		.ch4AudOut(ch4AudOut), .ch4AudOutValid(ch4AudOutValid)
	);

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// distinct ramps so each stream's age can be read from its value
	always @(posedge clk) begin
		ch2ModIn <= ch2ModIn + 16'h0001;
		ch3ModIn <= ch3ModIn + 16'h0001;
		ch4ModIn <= ch4ModIn + 16'h0001;
	end

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		regWrEn <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge clk);
		regWrEn <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		regRdEn <= 1'b1;
		regAddr <= a;
		@(posedge clk);
		regRdEn <= 1'b0;
		@(negedge clk);
		`CHK("regRdData", e, regRdData)
	endtask

	task automatic test_reset_values;
		rd(adc_cfg_pkg::ADDR_CH3_PHASE, 8'h00);
		rd(adc_cfg_pkg::ADDR_CH4_CLONE, 8'h00);
		rd(adc_cfg_pkg::ADDR_CH4_VOL, 8'hA1);
		rd(adc_cfg_pkg::ADDR_CH4_TRIM, 8'h80);
		rd(adc_cfg_pkg::ADDR_CH4_PHASE, 8'h00);
		rd(8'h62, 8'h00);
	endtask

	task automatic test_field_readback;
		wr(adc_cfg_pkg::ADDR_CH3_PHASE, 8'hFC);
		wr(adc_cfg_pkg::ADDR_CH4_CLONE, 8'h80);
		wr(adc_cfg_pkg::ADDR_CH4_TRIM, 8'hF0);
		wr(adc_cfg_pkg::ADDR_CH4_VOL, 8'hFF);
		wr(8'h62, 8'h5A);
		rd(adc_cfg_pkg::ADDR_CH3_PHASE, 8'hFC);
		rd(adc_cfg_pkg::ADDR_CH4_CLONE, 8'h80);
		rd(adc_cfg_pkg::ADDR_CH4_TRIM, 8'hF0);
		rd(adc_cfg_pkg::ADDR_CH4_VOL, 8'hFF);
		rd(8'h62, 8'h00);
		wr(adc_cfg_pkg::ADDR_CH4_TRIM, 8'h80);
		wr(adc_cfg_pkg::ADDR_CH4_VOL, 8'hA1);
	endtask

	// read issued in the cycle right after the write must see the new value
	task automatic test_back_to_back;
		@(posedge clk);
		regWrEn <= 1'b1;
		regAddr <= adc_cfg_pkg::ADDR_CH4_VOL;
		regWrData <= 8'h40;
		@(posedge clk);
		regWrEn <= 1'b0;
		regRdEn <= 1'b1;
		@(posedge clk);
		regRdEn <= 1'b0;
		@(negedge clk);
		`CHK("regRdData back to back", 8'h40, regRdData)
		wr(adc_cfg_pkg::ADDR_CH4_VOL, 8'hA1);
	endtask

	// output lags the word now on the input by the setting plus one
	task automatic test_phase(input int n3, input int n4, input bit cl);
		logic [15:0] src;
		wr(adc_cfg_pkg::ADDR_CH3_PHASE, 8'(n3 << 2));
		wr(adc_cfg_pkg::ADDR_CH4_PHASE, 8'(n4 << 2));
		wr(adc_cfg_pkg::ADDR_CH4_CLONE, {cl, 7'h00});
		repeat (70) @(posedge clk);
		@(negedge clk);
		src = cl ? ch2ModIn : ch4ModIn;
		`CHK("ch3ModOut", 16'(ch3ModIn - 16'(n3 + 1)), ch3ModOut)
		`CHK("ch4ModOut", 16'(src - 16'(n4 + 1)), ch4ModOut)
	endtask

	task automatic test_audio(input logic [7:0] v, input logic [3:0] t,
		input logic [23:0] x, input logic [23:0] e);
		wr(adc_cfg_pkg::ADDR_CH4_VOL, v);
		wr(adc_cfg_pkg::ADDR_CH4_TRIM, {t, 4'h0});
		@(posedge clk);
		ch4AudIn <= x;
		ch4AudInValid <= 1'b1;
		@(posedge clk);
		ch4AudInValid <= 1'b0;
		@(negedge clk);
		`CHK("ch4AudOutValid early", 1'b0, ch4AudOutValid)
		@(negedge clk);
		`CHK("ch4AudOutValid", 1'b1, ch4AudOutValid)
		`CHK("ch4AudOut", e, ch4AudOut)
	endtask

	task automatic end_of_test;
		$display("mismatches %0d comparisons %0d", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	initial begin
		#200000;
		mismatches++;
		end_of_test();
	end

	initial begin
		mismatches = 0;
		comparisons = 0;
		resetn = 1'b0;
		regWrEn = 1'b0;
		regRdEn = 1'b0;
		regAddr = 8'h00;
		regWrData = 8'h00;
		ch2ModIn = 16'h2000;
		ch3ModIn = 16'h0000;
		ch4ModIn = 16'h1000;
		ch4AudIn = 24'h000000;
		ch4AudInValid = 1'b0;
		repeat (4) @(posedge clk);
		resetn <= 1'b1;
		test_reset_values();
		test_audio(8'hA1, 4'h8, 24'h123456, 24'h123456);
		test_field_readback();
		test_back_to_back();
		test_phase(0, 63, 1'b0);
		test_phase(2, 1, 1'b1);
		test_phase(63, 0, 1'b0);
		test_audio(8'hAD, 4'h8, 24'h100000, 24'h200000);
		test_audio(8'h95, 4'h8, 24'h100000, 24'h080000);
		test_audio(8'hA1, 4'h0, 24'h100000, 24'h0E97C0);
		test_audio(8'h00, 4'h8, 24'h100000, 24'h000000);
		test_audio(8'hFF, 4'h8, 24'h100000, 24'h7FFFFF);
		end_of_test();
	end
endmodule
